// file: agc_cfg_pkg.sv
package agc_cfg_pkg;

  // Printed offsets are word indices; byte address is four times the index
  localparam logic [31:0] GAIN_LIMITS_IDX  = 32'h0000DF17;
  localparam logic [31:0] CARRIER_THR_IDX  = 32'h0000DF18;
  localparam logic [31:0] GAIN_LIMITS_ADDR = {GAIN_LIMITS_IDX[29:0], 2'b00};
  localparam logic [31:0] CARRIER_THR_ADDR = {CARRIER_THR_IDX[29:0], 2'b00};

  // Reset values
  localparam logic [7:0] GAIN_LIMITS_RST = 8'h03;
  localparam logic [6:0] CARRIER_THR_RST = 7'h40;

  // Field positions, gain limits and target register
  localparam int DG_HI   = 7;
  localparam int DG_LO   = 6;
  localparam int FA_HI   = 5;
  localparam int FA_LO   = 3;
  localparam int GOAL_HI = 2;
  localparam int GOAL_LO = 0;

  // Field positions, priority and carrier register
  localparam int ORDER_BIT = 6;
  localparam int RISE_HI   = 5;
  localparam int RISE_LO   = 4;
  localparam int LEVEL_HI  = 3;
  localparam int LEVEL_LO  = 0;

  localparam logic [3:0] LEVEL_OFF_CODE = 4'h8;
  localparam logic [1:0] RISE_OFF_CODE  = 2'h0;

  // Amplitude goal in dB per code
  localparam logic [5:0] GOAL_DB_TAB [8] = '{6'h18, 6'h1B, 6'h1E, 6'h21,
                                             6'h24, 6'h26, 6'h28, 6'h2A};
  // Front amplifier cap below maximum, tenths of a dB
  localparam logic [7:0] FA_CAP_TAB [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A,
                                            8'h5C, 8'h73, 8'h92, 8'hAB};
  // RSSI rise for relative carrier sense, dB
  localparam logic [3:0] RISE_DB_TAB [4] = '{4'h0, 4'h6, 4'hA, 4'hE};

  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] RDATA_RST     = 32'h00000000;

endpackage : agc_cfg_pkg

// file: carrier_detect.sv
`timescale 1ns/1ps
module carrier_detect
  import agc_cfg_pkg::*;
(
  input  wire logic [8:0] rssi_level,
  input  wire logic [8:0] baseline,
  input  wire logic [5:0] goal_db,
  input  wire logic [1:0] rise_code,
  input  wire logic [3:0] level_code,
  output logic            hit
);

  logic signed [9:0] level_thr;
  logic        [9:0] rise_thr;
  logic              abs_hit;
  logic              rel_hit;

  always_comb begin
    level_thr = $signed({4'h0, goal_db}) + $signed({{6{level_code[3]}}, level_code});
    rise_thr  = {1'b0, baseline} + {6'h00, RISE_DB_TAB[rise_code]};
    abs_hit   = (level_code != LEVEL_OFF_CODE)
                && ($signed({1'b0, rssi_level}) >= level_thr);
    rel_hit   = (rise_code != RISE_OFF_CODE) && ({1'b0, rssi_level} >= rise_thr);
    hit       = abs_hit | rel_hit;
  end

endmodule : carrier_detect

// file: agc_gain_carrier_config.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module agc_gain_carrier_config
  import agc_cfg_pkg::*;
#(
  parameter int DG_STEPS = 8
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  chan_amp_db,
  input  wire logic [7:0]  gain_cut_db,
  input  wire logic        rx_start,
  output logic [$clog2(DG_STEPS)-1:0] digital_gain_top_step,
  output logic [7:0]       front_amp_cap_tenth_db,
  output logic [5:0]       amplitude_goal_db,
  output logic             lna1_first,
  output logic [8:0]       rssi_level,
  output logic             carrier_sense
);

  localparam int SW = $clog2(DG_STEPS);

  typedef struct packed {
    logic [7:0]    gain_limits;
    logic [6:0]    carrier_thr;
    logic          wr_pend;
    logic          wr_gl;
    logic          wr_ct;
    logic          gl_written;
    logic [31:0]   rdata;
    logic [8:0]    baseline;
    logic [8:0]    rssi;
    logic          carrier;
    logic [SW-1:0] top_step;
    logic [7:0]    fa_cap;
    logic [5:0]    goal_db;
    logic          order;
    logic          ready;
    logic          resp;
  } state_t;

  state_t q;
  state_t d;

  logic       addr_ok;
  logic       hit_gl;
  logic       hit_ct;
  logic [8:0] rssi_now;
  logic       cs_hit;

  // Gain cut added back so level matches amplitude at zero cut
  assign rssi_now = {1'b0, chan_amp_db} + {1'b0, gain_cut_db};

  carrier_detect carrier_detect_i (
    .rssi_level (rssi_now),
    .baseline   (q.baseline),
    .goal_db    (q.goal_db),
    .rise_code  (q.carrier_thr[RISE_HI:RISE_LO]),
    .level_code (q.carrier_thr[LEVEL_HI:LEVEL_LO]),
    .hit        (cs_hit)
  );

  always_comb begin
    d       = q;
    addr_ok = hsel && hready && htrans[1];
    hit_gl  = haddr == GAIN_LIMITS_ADDR;
    hit_ct  = haddr == CARRIER_THR_ADDR;

    // Data phase of a write lands here, one edge after its address phase
    if (q.wr_pend) begin
      if (q.wr_gl) begin
        d.gain_limits = hwdata[7:0];
        d.gl_written  = 1'b1;
      end
      if (q.wr_ct) begin
        d.carrier_thr = hwdata[6:0];
      end
    end

    d.wr_pend = addr_ok && hwrite;
    d.wr_gl   = addr_ok && hwrite && hit_gl;
    d.wr_ct   = addr_ok && hwrite && hit_ct;

    // Read from next values so a read right behind a write sees it
    if (addr_ok && !hwrite) begin
      if (hit_gl) begin
        d.rdata = {24'h000000, d.gain_limits};
      end else if (hit_ct) begin
        d.rdata = {25'h0000000, d.carrier_thr};
      end else begin
        d.rdata = RDATA_RST;
      end
    end

    d.top_step = SW'(DG_STEPS - 1 - int'(d.gain_limits[DG_HI:DG_LO]));
    d.fa_cap   = FA_CAP_TAB[d.gain_limits[FA_HI:FA_LO]];
    d.goal_db  = GOAL_DB_TAB[d.gain_limits[GOAL_HI:GOAL_LO]];
    d.order    = d.carrier_thr[ORDER_BIT];

    // Relative sensing measures rise from level seen at receive start
    if (rx_start) begin
      d.baseline = rssi_now;
    end
    d.rssi    = rssi_now;
    d.carrier = cs_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.gain_limits <= GAIN_LIMITS_RST;
      q.carrier_thr <= CARRIER_THR_RST;
      q.wr_pend     <= 1'b0;
      q.wr_gl       <= 1'b0;
      q.wr_ct       <= 1'b0;
      q.gl_written  <= 1'b0;
      q.rdata       <= RDATA_RST;
      q.baseline    <= 9'h000;
      q.rssi        <= 9'h000;
      q.carrier     <= 1'b0;
      q.top_step    <= SW'(DG_STEPS - 1);
      q.fa_cap      <= FA_CAP_TAB[0];
      q.goal_db     <= GOAL_DB_TAB[3];
      q.order       <= 1'b1;
      q.ready       <= 1'b1;
      q.resp        <= 1'b0;
    end else if (ce) begin
      q <= d;
    end
  end

  // Zero wait states; every transfer answers OKAY
  // Response held in flops so every output leaves a register
  assign hreadyout              = q.ready;
  assign hresp                  = q.resp;
  assign hrdata                 = q.rdata;
  assign digital_gain_top_step  = q.top_step;
  assign front_amp_cap_tenth_db = q.fa_cap;
  assign amplitude_goal_db      = q.goal_db;
  assign lna1_first             = q.order;
  assign rssi_level             = q.rssi;
  assign carrier_sense          = q.carrier;

  a_digital_ceiling: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.wr_pend && q.wr_gl)
    |=> int'(q.top_step) == DG_STEPS - 1 - int'($past(hwdata[7:6])))
    else $error("digital ceiling step wrong");

  a_front_cap_map: assert property (@(posedge hclk) disable iff (!hresetn)
    q.fa_cap == FA_CAP_TAB[q.gain_limits[FA_HI:FA_LO]])
    else $error("front amp cap mismatch");

  a_goal_map: assert property (@(posedge hclk) disable iff (!hresetn)
    q.goal_db == GOAL_DB_TAB[q.gain_limits[GOAL_HI:GOAL_LO]])
    else $error("amplitude goal mismatch");

  a_reset_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.gl_written |-> (q.gain_limits == GAIN_LIMITS_RST && q.top_step == SW'(DG_STEPS - 1)))
    else $error("ceilings not at reset value");

  a_order_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.wr_pend && q.wr_ct) |=> lna1_first == $past(hwdata[6]))
    else $error("reduction order not applied");

  a_both_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == {RISE_OFF_CODE, LEVEL_OFF_CODE}) |=> !carrier_sense)
    else $error("carrier with both thresholds off");

  a_level_at_goal: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h00 && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} == {4'h0, q.goal_db}) |=> carrier_sense)
    else $error("no carrier at goal level");

  a_level_below: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h0F && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} + 10'h001 == {4'h0, q.goal_db}) |=> carrier_sense)
    else $error("no carrier one dB below goal");

  a_level_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h07 && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} + 10'h001 == {4'h0, q.goal_db} + 10'h007) |=> !carrier_sense)
    else $error("carrier below absolute threshold");

  a_rise_sense: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h18 && {1'b0, rssi_now} >= {1'b0, q.baseline} + 10'h006)
    |=> carrier_sense)
    else $error("no carrier on 6 dB rise");

  a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && hit_ct) |=> hrdata[31:7] == 25'h0000000)
    else $error("unused bit not zero");

  // Bus side: read data, register writes and dropped writes
  a_gl_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && hit_gl)
    |=> hrdata == {24'h000000, q.gain_limits})
    else $error("gain limits read back wrong");

  a_ct_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && hit_ct)
    |=> hrdata == {25'h0000000, q.carrier_thr})
    else $error("carrier register read back wrong");

  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_ok && !hwrite && !hit_gl && !hit_ct)
    |=> hrdata == RDATA_RST)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(ce && addr_ok && !hwrite)
    |=> $stable(hrdata))
    else $error("read data moved without a read");

  a_gl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.wr_pend && q.wr_gl)
    |=> q.gain_limits == $past(hwdata[7:0]))
    else $error("gain limits write lost");

  a_ct_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.wr_pend && q.wr_ct)
    |=> q.carrier_thr == $past(hwdata[6:0]))
    else $error("carrier register write lost");

  a_write_dropped: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.wr_pend && !q.wr_gl && !q.wr_ct)
    |=> $stable(q.gain_limits) && $stable(q.carrier_thr))
    else $error("unmapped write changed a register");

  // Datapath: registered level and carrier
  a_rssi_track: assert property (@(posedge hclk) disable iff (!hresetn)
    ce
    |=> rssi_level == $past(rssi_now))
    else $error("rssi level not registered amplitude");

  a_carrier_track: assert property (@(posedge hclk) disable iff (!hresetn)
    ce
    |=> carrier_sense == $past(cs_hit))
    else $error("carrier sense not registered hit");

  a_baseline_grab: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && rx_start)
    |=> q.baseline == $past(rssi_now))
    else $error("baseline not captured");

  a_rise_ten: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h28 && {1'b0, rssi_now} >= {1'b0, q.baseline} + 10'h00A)
    |=> carrier_sense)
    else $error("no carrier on 10 dB rise");

  a_rise_fourteen: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h38 && {1'b0, rssi_now} >= {1'b0, q.baseline} + 10'h00E)
    |=> carrier_sense)
    else $error("no carrier on 14 dB rise");

  a_rise_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[3:0] == LEVEL_OFF_CODE
     && {1'b0, rssi_now} < {1'b0, q.baseline} + {6'h00, RISE_DB_TAB[q.carrier_thr[5:4]]})
    |=> !carrier_sense)
    else $error("carrier with level sensing off");

  a_level_above: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h07 && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} == {4'h0, q.goal_db} + 10'h007) |=> carrier_sense)
    else $error("no carrier seven dB above goal");

  a_level_lowest: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h09 && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} + 10'h007 == {4'h0, q.goal_db}) |=> carrier_sense)
    else $error("no carrier seven dB below goal");

  a_goal_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && q.carrier_thr[5:0] == 6'h00 && gain_cut_db == 8'h00
     && {2'b00, chan_amp_db} + 10'h001 == {4'h0, q.goal_db}) |=> !carrier_sense)
    else $error("carrier one dB below goal");

  // Freeze: a low enable must hold every flop
  a_freeze_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !ce
    |=> $stable(q))
    else $error("state moved while enable low");

endmodule : agc_gain_carrier_config

// file: agc_gain_carrier_config_bench.sv
`timescale 1ns/1ps
module agc_gain_carrier_config_bench;
  import agc_cfg_pkg::*;
  localparam logic [5:0] EXP_GOAL [8] = '{6'h18, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A};
  localparam logic [7:0] EXP_CAP [8]  = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
  localparam logic [7:0] EXP_RISE [4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};
  logic        hclk, hresetn, ce, hsel, hwrite, rx_start;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  chan_amp_db, gain_cut_db, v;
  logic        hready, hresp, lna1_first, carrier_sense;
  logic [31:0] hrdata;
  logic [2:0]  top;
  logic [7:0]  cap;
  logic [5:0]  goal;
  logic [8:0]  rssi;
  int          fails, checks, cyc;

  agc_gain_carrier_config #(.DG_STEPS(8)) agc_gain_carrier_config_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .chan_amp_db(chan_amp_db), .gain_cut_db(gain_cut_db),
    .rx_start(rx_start), .digital_gain_top_step(top), .front_amp_cap_tenth_db(cap),
    .amplitude_goal_db(goal), .lna1_first(lna1_first), .rssi_level(rssi),
    .carrier_sense(carrier_sense));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Starts on the next edge; waits on hready in both phases, never a count
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
    #1;
  endtask : ahb

  // Result shows one edge after the inputs are driven
  task cs_at(input logic [7:0] amp, input logic e);
    @(posedge hclk);
    chan_amp_db <= amp;
    @(posedge hclk);
    @(posedge hclk);
    #1;
    chk(32'(carrier_sense), 32'(e));
    chk(32'(rssi), 32'(amp) + 32'(gain_cut_db));
  endtask : cs_at

  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Whole run is a few hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b1; hwrite = 1'b0; rx_start = 1'b0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
    chan_amp_db = 8'h00; gain_cut_db = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, GAIN_LIMITS_ADDR, 32'h0);
    chk(rd, 32'h03);
    chk(32'(top), 32'h7);
    chk(32'(goal), 32'h21);
    ahb(1'b0, CARRIER_THR_ADDR, 32'h0);
    chk(rd, 32'h40);
    chk(32'(lna1_first), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], i[2:0]};
      ahb(1'b1, GAIN_LIMITS_ADDR, 32'(v));
      chk(32'(top), 32'(7 - i % 4));
      chk(32'(cap), 32'(EXP_CAP[i]));
      chk(32'(goal), 32'(EXP_GOAL[i]));
      ahb(1'b0, GAIN_LIMITS_ADDR, 32'h0);
      chk(rd, 32'(v));
    end
    $display("test gain fields done");
    ahb(1'b1, CARRIER_THR_ADDR, 32'hFF);
    ahb(1'b0, CARRIER_THR_ADDR, 32'h0);
    chk(rd, 32'h7F);
    ahb(1'b1, CARRIER_THR_ADDR, 32'h00);
    chk(32'(lna1_first), 32'h0);
    ahb(1'b1, 32'h00037C64, 32'hFF);
    ahb(1'b0, 32'h00037C64, 32'h0);
    chk(rd, 32'h0);
    @(posedge hclk);
    ce <= 1'b0;
    ahb(1'b1, CARRIER_THR_ADDR, 32'h7F);
    @(posedge hclk);
    ce <= 1'b1;
    ahb(1'b0, CARRIER_THR_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test carrier register done");
    // Goal 33 dB; relative sensing off so only the level decides
    ahb(1'b1, GAIN_LIMITS_ADDR, 32'h03);
    for (int c = 0; c < 16; c++) begin
      ahb(1'b1, CARRIER_THR_ADDR, 32'(c));
      v = 8'(33 + ((c > 7) ? c - 16 : c));
      cs_at(v, c != 8);
      cs_at(v - 8'h01, 1'b0);
    end
    $display("test level threshold done");
    @(posedge hclk);
    gain_cut_db <= 8'h03;
    chan_amp_db <= 8'h14;
    rx_start <= 1'b1;
    @(posedge hclk);
    rx_start <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      ahb(1'b1, CARRIER_THR_ADDR, 32'({2'(r), 4'h8}));
      cs_at(8'h13 + EXP_RISE[r], 1'b0);
      cs_at(8'h14 + EXP_RISE[r], r != 0);
    end
    ahb(1'b1, CARRIER_THR_ADDR, 32'h00);
    cs_at(8'h1E, 1'b1);
    $display("test rise threshold done");
    finish_test();
  end
endmodule : agc_gain_carrier_config_bench
